// *** rtl/wss_sequencer.v ***
// Behaviour
// - delay-select set: entry is idle time
// - idle lasts value times 10 ms
// - delay-select clear: entry is waveform identifier
// - identifier indexes the waveform library
// - trigger starts playback at first slot
// - after waveform, advance to next slot
// - stop after eighth entry or zero
// - zero value stops the sequencer
// - bit 7 flag, bits 6-0 value, reset 0
`timescale 1ns/1ps
`include "wss_defines.vh"

module wss_sequencer #(
  parameter STEP_CYCLES = `WSS_STEP_CYCLES,
  parameter TICK_W = `WSS_TICK_W
) (
  input wire clock_i,
  input wire resetn_i,
  input wire ce_i,
  input wire [`WSS_ADDR_W-1:0] reg_addr_i,
  input wire reg_wr_i,
  input wire [7:0] reg_wdata_i,
  input wire reg_rd_i,
  output wire [7:0] reg_rdata_o,
  input wire go_i,
  input wire wave_done_i,
  output wire wave_start_o,
  output wire [6:0] wave_id_o,
  output wire busy_o,
  output wire idle_delay_o,
  output wire [2:0] cur_slot_o
);

  // ===================================================================
  // states
  localparam [3:0] ST_IDLE = 4'h1;
  localparam [3:0] ST_FETCH = 4'h2;
  localparam [3:0] ST_PLAY = 4'h4;
  localparam [3:0] ST_WAIT = 4'h8;
  localparam [TICK_W-1:0] TICK_ONE = {{(TICK_W-1){1'b0}}, 1'b1};

  // counts are cut to their register widths on purpose
  localparam [31:0] STEP_W32 = STEP_CYCLES;
  localparam [TICK_W-1:0] TICK_LAST = STEP_W32[TICK_W-1:0] - TICK_ONE;
  localparam [31:0] SLOT_LAST32 = `WSS_SLOT_COUNT - 1;
  localparam [2:0] SLOT_END = SLOT_LAST32[2:0];

  // idle -> fetch on go; fetch -> play, wait or idle by the entry
  // play -> fetch on done; wait -> fetch when the delay runs out; either -> idle instead at the last slot

  // ===================================================================
  // sequence table
  reg [7:0] slot_ff [0:`WSS_SLOT_COUNT-1];
  reg [7:0] rdata_ff;
  reg [7:0] nxt_rdata;
  wire [`WSS_ADDR_W-1:0] slot_off;
  wire addr_above_first;
  wire addr_below_last;
  wire addr_hit;
  wire [`WSS_SLOT_COUNT-1:0] slot_we;
  wire [`WSS_SLOT_COUNT-1:0] slot_delay_sel;
  wire [6:0] slot_value [0:`WSS_SLOT_COUNT-1];

  // slot index is the offset from the first slot address
  assign slot_off = reg_addr_i - `WSS_SLOT_FIRST;
  assign addr_above_first = (reg_addr_i >= `WSS_SLOT_FIRST);
  assign addr_below_last = (reg_addr_i <= `WSS_SLOT_LAST);
  assign addr_hit = addr_above_first && addr_below_last;

  // write strobes, one per slot
  genvar gi;
  generate
    for (gi = 0; gi < `WSS_SLOT_COUNT; gi = gi + 1) begin : g_slot
      assign slot_we[gi] = ce_i && reg_wr_i && addr_hit &&
                           (slot_off[2:0] == gi);
      assign slot_delay_sel[gi] = slot_ff[gi][`WSS_DELAY_SEL_BIT];
      assign slot_value[gi] = slot_ff[gi][`WSS_VALUE_MSB:`WSS_VALUE_LSB];

      always @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
          slot_ff[gi] <= `WSS_SLOT_RESET;
        end else if (slot_we[gi]) begin
          slot_ff[gi] <= reg_wdata_i;
        end
      end
    end
  endgenerate

  // ===================================================================
  // register read path
  // read data is registered; unmapped addresses read as zero
  always @* begin
    nxt_rdata = `WSS_UNMAPPED_READ;
    if (addr_hit) begin
      nxt_rdata = slot_ff[slot_off[2:0]];
    end
  end

  always @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rdata_ff <= `WSS_UNMAPPED_READ;
    end else if (ce_i && reg_rd_i) begin
      rdata_ff <= nxt_rdata;
    end
  end

  // ===================================================================
  // playback sequencer
  reg [3:0] state_ff;
  reg [3:0] nxt_state;

  reg [2:0] slot_idx_ff;
  reg [2:0] nxt_slot_idx;

  reg [6:0] delay_ff;
  reg [6:0] nxt_delay;

  reg [TICK_W-1:0] tick_ff;
  reg [TICK_W-1:0] nxt_tick;

  reg start_ff;
  reg nxt_start;

  reg [6:0] wave_id_ff;
  reg [6:0] nxt_wave_id;

  reg busy_ff;
  reg nxt_busy;

  wire entry_delay;
  wire [6:0] entry_val;
  wire entry_stop;
  wire slot_is_last;
  wire [2:0] slot_next;
  wire tick_wrap;
  wire delay_last;

  // ===================================================================
  // entry decode
  // the entry under the cursor, split into its two fields
  assign entry_delay = slot_delay_sel[slot_idx_ff];
  assign entry_val = slot_value[slot_idx_ff];

  // a zero value ends the sequence whatever its type
  assign entry_stop = (entry_val == 7'h00);

  // the eighth slot is the last one played
  assign slot_is_last = (slot_idx_ff == SLOT_END);
  assign slot_next = slot_idx_ff + 3'h1;

  // one wrap of the tick counter is one 10 ms step
  assign tick_wrap = (tick_ff == TICK_LAST);
  assign delay_last = (delay_ff == 7'h01);

  // ===================================================================
  // next-state logic
  always @* begin
    nxt_state = state_ff;
    nxt_slot_idx = slot_idx_ff;
    nxt_delay = delay_ff;
    nxt_tick = tick_ff;
    nxt_start = 1'b0;
    nxt_wave_id = wave_id_ff;
    nxt_busy = 1'b0;
    case (state_ff)
      // wait for the trigger
      ST_IDLE: begin
        if (go_i) begin
          nxt_slot_idx = 3'h0;
          nxt_state = ST_FETCH;
        end
      end
      // look at the entry under the cursor
      ST_FETCH: begin
        if (entry_stop) begin
          nxt_state = ST_IDLE;
        end else if (entry_delay) begin
          // delay entry: idle for value steps
          nxt_delay = entry_val;
          nxt_tick = {TICK_W{1'b0}};
          nxt_state = ST_WAIT;
        end else begin
          nxt_wave_id = entry_val;
          nxt_start = 1'b1;
          nxt_state = ST_PLAY;
        end
      end
      // the library plays the waveform
      ST_PLAY: begin
        if (wave_done_i) begin
          if (slot_is_last) begin
            nxt_state = ST_IDLE;
          end else begin
            nxt_slot_idx = slot_next;
            nxt_state = ST_FETCH;
          end
        end
      end
      // count the delay one step at a time
      ST_WAIT: begin
        if (tick_wrap) begin
          nxt_tick = {TICK_W{1'b0}};
          nxt_delay = delay_ff - 7'h01;
          if (delay_last) begin
            if (slot_is_last) begin
              nxt_state = ST_IDLE;
            end else begin
              nxt_slot_idx = slot_next;
              nxt_state = ST_FETCH;
            end
          end
        end else begin
          nxt_tick = tick_ff + TICK_ONE;
        end
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
    // busy is registered so the port comes from a flop
    nxt_busy = (nxt_state != ST_IDLE);
  end

  // ===================================================================
  // state registers
  // every register below holds still while ce_i is low

  always @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_ff <= ST_IDLE;
    end else if (ce_i) begin
      state_ff <= nxt_state;
    end
  end

  // cursor into the sequence table
  always @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      slot_idx_ff <= 3'h0;
    end else if (ce_i) begin
      slot_idx_ff <= nxt_slot_idx;
    end
  end

  // remaining 10 ms steps of a delay entry
  always @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      delay_ff <= 7'h00;
    end else if (ce_i) begin
      delay_ff <= nxt_delay;
    end
  end

  // cycles within the current step
  always @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      tick_ff <= {TICK_W{1'b0}};
    end else if (ce_i) begin
      tick_ff <= nxt_tick;
    end
  end

  // start strobe towards the waveform library
  always @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      start_ff <= 1'b0;
    end else if (ce_i) begin
      start_ff <= nxt_start;
    end
  end

  // library index, held until the next start
  always @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      wave_id_ff <= 7'h00;
    end else if (ce_i) begin
      wave_id_ff <= nxt_wave_id;
    end
  end

  // high from the first fetch until the sequence ends
  always @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      busy_ff <= 1'b0;
    end else if (ce_i) begin
      busy_ff <= nxt_busy;
    end
  end

  // ===================================================================
  // outputs
  // every port is driven straight from a register
  assign reg_rdata_o = rdata_ff;
  assign wave_start_o = start_ff;
  assign wave_id_o = wave_id_ff;
  assign busy_o = busy_ff;
  assign idle_delay_o = state_ff[3];
  assign cur_slot_o = slot_idx_ff;

endmodule // wss_sequencer

// *** common/wss_defines.vh ***
`ifndef WSS_DEFINES_VH
`define WSS_DEFINES_VH

// =====================================================================
// register map
`define WSS_ADDR_W 8
`define WSS_SLOT_FIRST 8'h0f
`define WSS_SLOT_THREE 8'h11
`define WSS_SLOT_FOUR 8'h12
`define WSS_SLOT_LAST 8'h16
`define WSS_SLOT_COUNT 8
`define WSS_SLOT_RESET 8'h00
`define WSS_UNMAPPED_READ 8'h00

// =====================================================================
// entry fields
`define WSS_DELAY_SEL_BIT 7
`define WSS_VALUE_MSB 6
`define WSS_VALUE_LSB 0

// =====================================================================
// timing
`define WSS_CLK_KHZ 25000
`define WSS_STEP_MS 10
`define WSS_STEP_CYCLES (`WSS_STEP_MS * `WSS_CLK_KHZ)
`define WSS_TICK_W 18

`endif

// *** tb/wss_assertions.sv ***
`timescale 1ns/1ps
// ==========================================
// sequencer port checks
module wss_checker #(parameter STEP_CYCLES = 250000) (
  input wire clock_i, resetn_i, ce_i, reg_rd_i, go_i,
  input wire wave_done_i, wave_start_o, busy_o, idle_delay_o,
  input wire [7:0] reg_addr_i, reg_rdata_o,
  input wire [6:0] wave_id_o,
  input wire [2:0] cur_slot_o);
  default clocking @(posedge clock_i); endclocking
  default disable iff (!resetn_i);
  int cnt;
  always @(posedge clock_i or negedge resetn_i)
    if (!resetn_i) cnt <= 0;
    else if (ce_i) cnt <= idle_delay_o ? cnt + 1 : 0;
  sequence go_taken; ce_i && go_i && !busy_o; endsequence
  start_first_a: assert property (go_taken |=>
    busy_o && cur_slot_o == 3'h0) else $error("bad start");
  delay_quiet_a: assert property (idle_delay_o |->
    !wave_start_o) else $error("wave in delay");
  id_hold_a: assert property ($changed(wave_id_o) |->
    wave_start_o) else $error("id moved");
  delay_len_a: assert property ($fell(idle_delay_o) |->
    cnt > 0 && cnt % STEP_CYCLES == 0) else $error("delay len");
  slot_step_a: assert property (busy_o && $past(busy_o) &&
    $changed(cur_slot_o) |-> cur_slot_o == $past(cur_slot_o) + 3'h1)
    else $error("slot skip");
  idle_out_a: assert property (!busy_o |->
    !idle_delay_o && !wave_start_o) else $error("idle active");
  last_stop_a: assert property (busy_o && cur_slot_o == 3'h7 &&
    ce_i && wave_done_i && !idle_delay_o |-> ##[1:2] !busy_o)
    else $error("no stop");
  unmapped_zero_a: assert property (ce_i && reg_rd_i &&
    (reg_addr_i < 8'h0f || reg_addr_i > 8'h16) |=> reg_rdata_o == 8'h00)
    else $error("unmapped data");
endmodule // wss_checker

bind wss_sequencer wss_checker #(.STEP_CYCLES(STEP_CYCLES)) u_chk (
  .clock_i(clock_i), .resetn_i(resetn_i), .ce_i(ce_i),
  .reg_rd_i(reg_rd_i), .go_i(go_i), .wave_done_i(wave_done_i),
  .wave_start_o(wave_start_o), .busy_o(busy_o),
  .idle_delay_o(idle_delay_o), .reg_addr_i(reg_addr_i),
  .reg_rdata_o(reg_rdata_o), .wave_id_o(wave_id_o),
  .cur_slot_o(cur_slot_o));

// *** tb/test_waveform_sequence_slots.sv ***
`timescale 1ns/1ps
// ==========================================
// sequencer bench
module test_waveform_sequence_slots;
  localparam int STEP = 10;
  logic clock = 0, resetn = 0, wr = 0, rd = 0, go = 0, done = 0, ce = 1;
  logic [7:0] addr = 0, wdat = 0, v;
  logic [6:0] id [8];
  int mismatches = 0, compares = 0, k, n, d, dcnt = 0;
  event fin;
  wire [7:0] rdat;
  wire ws, busy, dly;
  wire [6:0] wid;
  wire [2:0] slot;
  wss_sequencer #(.STEP_CYCLES(STEP)) DUT (.clock_i(clock),
    .resetn_i(resetn), .ce_i(ce), .reg_addr_i(addr), .reg_wr_i(wr),
    .reg_wdata_i(wdat), .reg_rd_i(rd), .reg_rdata_o(rdat), .go_i(go),
    .wave_done_i(done), .wave_start_o(ws), .wave_id_o(wid),
    .busy_o(busy), .idle_delay_o(dly), .cur_slot_o(slot));
  initial forever #20 clock = ~clock;
  // cycles spent in a timed delay
  always @(negedge clock) dcnt <= dcnt + (dly === 1'b1);
  task chk(input [7:0] s, e);
    compares++;
    if (s !== e) begin
      mismatches++;
      $display("mismatch %0t seen %h want %h", $time, s, e);
    end
  endtask
  task complete_run;
    $display("mismatches %0d compares %0d", mismatches, compares);
    if (mismatches == 0 && compares > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task wreg(input [7:0] a, dt);
    @(negedge clock) addr = a; wdat = dt; wr = 1;
    @(negedge clock) wr = 0;
  endtask
  task rreg(input [7:0] a, e);
    @(negedge clock) addr = a; rd = 1;
    @(negedge clock) rd = 0;
    chk(rdat, e);
  endtask
  task start;
    @(negedge clock) go = 1;
    @(negedge clock) go = 0;
  endtask
  // wait for a start pulse, then check what it plays and from where
  task serve(input [6:0] e, input [2:0] s);
    n = 0;
    while (ws !== 1'b1 && n < 300) begin
      @(negedge clock);
      n++;
    end
    if (n == 300) begin
      mismatches++;
      -> fin;
      disable body;
    end
    chk({1'b0, wid}, {1'b0, e});
    chk({5'h0, slot}, {5'h0, s});
    @(negedge clock) done = 1;
    @(negedge clock) done = 0;
  endtask
  initial begin : body
    v = 8'($urandom(32'h914dcec8));
    repeat (6) @(negedge clock);
    resetn = 1;
    rreg(8'h11, 8'h00);
    rreg(8'h12, 8'h00);
    v = 8'($urandom);
    wreg(8'h12, v);
    rreg(8'h12, v);
    rreg(8'h40, 8'h00);
    for (k = 0; k < 8; k++) id[k] = 7'($urandom_range(127, 1));
    wreg(8'h0f, {1'b0, id[0]});
    wreg(8'h10, 8'h82);
    wreg(8'h11, {1'b0, id[2]});
    wreg(8'h12, 8'h80);
    start;
    serve(id[0], 3'h0);
    d = dcnt;
    start; // go while busy must be ignored
    serve(id[2], 3'h2);
    chk(8'(dcnt - d), 8'(2 * STEP));
    repeat (3) @(negedge clock);
    chk({7'h0, busy}, 8'h00);
    for (k = 0; k < 8; k++) wreg(8'(8'h0f + k), {1'b0, id[k]});
    start;
    for (k = 0; k < 8; k++) serve(id[k], 3'(k));
    repeat (3) @(negedge clock);
    chk({7'h0, busy}, 8'h00);
    ce = 0;
    wreg(8'h11, 8'h55);
    ce = 1;
    rreg(8'h11, {1'b0, id[2]});
    -> fin;
  end
  initial begin
    @(fin);
    complete_run;
  end
endmodule // test_waveform_sequence_slots
